// *** bench/breaker_far_side.sv ***
`timescale 1ns/1ns
module breaker_far_side (
	input wire logic ref_clk,
	input wire logic [1:0] close_cmd,
	input wire logic [1:0] open_cmd,
	input wire logic [1:0] stuck,
	input wire logic [1:0] ext_en,
	input wire logic [1:0] ext_state,
	output logic [1:0] feedback
);
	// [0]=mains, [1]=gen; a stuck breaker ignores its coils
	logic [1:0] pos = 2'h0;
	logic [1:0] lag = 2'h0;
	logic [1:0] next_pos;
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			next_pos[i] = pos[i];
			if (ext_en[i])
				next_pos[i] = ext_state[i];
			else if (close_cmd[i] && !stuck[i])
				next_pos[i] = 1'b1;
			else if (open_cmd[i] && !stuck[i])
				next_pos[i] = 1'b0;
		end
	end
	// contacts settle on feedback three cycles after the coil command
	always_ff @(posedge ref_clk) begin
		pos <= next_pos;
		lag <= pos;
		feedback <= lag;
	end
endmodule : breaker_far_side

// *** bench/tb_top.sv ***
`timescale 1ns/1ns
module tb_top
	import brk_pkg::*;
;
	logic ref_clk = 1'b0;
	logic resetn = 1'b0;
	op_mode_t mode = MODE_MAN;
	logic m_cc = 0, m_oc = 0, g_cc = 0, g_oc = 0, m_ov = 0, g_ov = 0, m_cr = 0, m_or = 0, g_cr = 0, g_or = 0;
	logic m_sr = 0, g_sr = 0, inh = 0, m_cs = 0, m_os = 0, g_cs = 0, g_os = 0, m_bo = 0, g_bo = 0;
	logic [1:0] fb_cfg = 2'h3, cc_cfg = 2'h0, oc_cfg = 2'h0, src_pw = 2'h0, ext_sync = 2'h0, ext_man = 2'h0;
	logic [DLY_W-1:0] consent_dly = 16'h0001, fb_dly = 16'h0001;
	logic m_live = 1, g_live = 1, sync_reached = 0;
	logic [1:0] stuck = 2'h0, ext_en = 2'h0, ext_state = 2'h0, fb;
	logic m_rc, m_ro, g_rc, g_ro, m_ccmd, m_ocmd, g_ccmd, g_ocmd, m_led, g_led;
	logic m_fc, m_fo, g_fc, g_fo, g_se, m_se, sip, synced;
	int num_errors = 0, num_checks = 0, cycles = 0;

	breaker_handshake_io_logic breaker_handshake_io_logic_i (.ref_clk(ref_clk), .resetn(resetn), .mode(mode),
		.mains_brk_close_consent_in(m_cc), .mains_brk_open_consent_in(m_oc), .gen_brk_close_consent_in(g_cc),
		.gen_brk_open_consent_in(g_oc), .mains_brk_feedback_in(fb[0]), .gen_brk_feedback_in(fb[1]),
		.mains_brk_override_in(m_ov), .gen_brk_override_in(g_ov), .mains_brk_close_request_in(m_cr),
		.mains_brk_open_request_in(m_or), .gen_brk_close_request_in(g_cr), .gen_brk_open_request_in(g_or),
		.mains_brk_sync_request_in(m_sr), .gen_brk_sync_request_in(g_sr), .mains_brk_inhibit_in(inh),
		.mains_close_seq(m_cs), .mains_open_seq(m_os), .gen_close_seq(g_cs), .gen_open_seq(g_os),
		.mains_open_blackout(m_bo), .gen_open_blackout(g_bo), .fb_cfg(fb_cfg), .close_consent_cfg(cc_cfg),
		.open_consent_cfg(oc_cfg), .consent_dly(consent_dly), .fb_dly(fb_dly), .src_powered(src_pw),
		.mains_live(m_live), .gen_bus_live(g_live), .ext_sync_used(ext_sync), .ext_managed(ext_man),
		.sync_reached(sync_reached), .mains_brk_ready_close_out(m_rc), .mains_brk_ready_open_out(m_ro),
		.gen_brk_ready_close_out(g_rc), .gen_brk_ready_open_out(g_ro), .mains_brk_close_cmd(m_ccmd),
		.mains_brk_open_cmd(m_ocmd), .gen_brk_close_cmd(g_ccmd), .gen_brk_open_cmd(g_ocmd),
		.mains_brk_closed_led(m_led), .gen_brk_closed_led(g_led), .mains_brk_fail_close(m_fc),
		.mains_brk_fail_open(m_fo), .gen_brk_fail_close(g_fc), .gen_brk_fail_open(g_fo),
		.gen_brk_sync_enable_out(g_se), .mains_brk_sync_enable_out(m_se), .sync_in_progress_out(sip),
		.synchronized_out(synced));
	breaker_far_side breaker_far_side_i (.ref_clk(ref_clk), .close_cmd({g_ccmd, m_ccmd}),
		.open_cmd({g_ocmd, m_ocmd}), .stuck(stuck), .ext_en(ext_en), .ext_state(ext_state), .feedback(fb));

	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	// ceiling well above the few hundred cycles the scenarios need
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			test_done();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : tick
	task automatic check(input logic seen, input logic exp, input string msg);
		num_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask : check
	task automatic test_done();
		if (num_errors == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : test_done
	////////////////////////////////////////////////////////////////
	// consent delay is 1 unit (100000 cycles), so only the consent pin can release
	task automatic t_close_consent();
		cc_cfg = 2'h2;
		g_cs = 1;
		for (int i = 0; i < 20 && g_rc !== 1'b1; i++) tick(1);
		check(g_rc, 1'b1, "no ready to close");
		tick(10);
		check(g_ccmd, 1'b0, "closed before consent");
		g_cc = 1;
		for (int i = 0; i < 20 && g_ccmd !== 1'b1; i++) tick(1);
		check(g_ccmd, 1'b1, "no close after consent");
		check(g_rc, 1'b0, "ready to close held");
		check(g_ocmd, 1'b0, "open with close");
		for (int i = 0; i < 20 && g_led !== 1'b1; i++) tick(1);
		check(g_led, 1'b1, "closed not shown");
		g_cs = 0;
		g_cc = 0;
		cc_cfg = 2'h0;
	endtask : t_close_consent
	task automatic t_open_consent();
		oc_cfg = 2'h2;
		g_bo = 1;
		g_os = 1;
		for (int i = 0; i < 20 && g_ro !== 1'b1; i++) tick(1);
		check(g_ro, 1'b1, "no ready to open");
		tick(10);
		check(g_ocmd, 1'b0, "opened before consent");
		g_oc = 1;
		for (int i = 0; i < 20 && g_ocmd !== 1'b1; i++) tick(1);
		check(g_ro, 1'b0, "ready to open held");
		for (int i = 0; i < 20 && g_led !== 1'b0; i++) tick(1);
		check(g_led, 1'b0, "open not shown");
		g_os = 0;
		g_oc = 0;
		g_bo = 0;
		oc_cfg = 2'h0;
	endtask : t_open_consent
	// zero feedback delay and a stuck breaker: failure is declared quickly
	task automatic t_fail();
		fb_dly = 16'h0000;
		stuck = 2'h2;
		g_cs = 1;
		for (int i = 0; i < 60 && g_fc !== 1'b1; i++) tick(1);
		check(g_fc, 1'b1, "no failed close");
		check(g_led, 1'b0, "stuck shown closed");
		g_cs = 0;
		// let the last close pulse pass the stuck breaker before freeing it
		tick(5);
		stuck = 2'h0;
		fb_dly = 16'h0001;
		tick(5);
	endtask : t_fail
	task automatic t_manual();
		mode = MODE_AUTO;
		m_cr = 1;
		tick(15);
		check(m_ccmd, 1'b0, "request honoured in auto");
		mode = MODE_MAN;
		for (int i = 0; i < 20 && m_ccmd !== 1'b1; i++) tick(1);
		check(m_ccmd, 1'b1, "request ignored in manual");
		m_cr = 0;
		for (int i = 0; i < 20 && m_led !== 1'b1; i++) tick(1);
	endtask : t_manual
	task automatic t_inhibit();
		mode = MODE_AUTO;
		inh = 1;
		for (int i = 0; i < 20 && m_ocmd !== 1'b1; i++) tick(1);
		check(m_ocmd, 1'b1, "inhibit did not open");
		for (int i = 0; i < 20 && m_led !== 1'b0; i++) tick(1);
		m_cs = 1;
		tick(15);
		check(m_ccmd, 1'b0, "closed while inhibited");
		m_cs = 0;
		inh = 0;
		mode = MODE_MAN;
	endtask : t_inhibit
	task automatic t_override();
		m_ov = 1;
		// the override pin needs its sync cycles before the close request follows
		tick(4);
		m_cs = 1;
		ext_en = 2'h1;
		ext_state = 2'h1;
		for (int i = 0; i < 15; i++) begin
			tick(1);
			check(m_ccmd | m_ocmd, 1'b0, "command under override");
		end
		check(m_led, 1'b1, "external close not tracked");
		ext_en = 2'h0;
		m_cs = 0;
		m_ov = 0;
		for (int i = 0; i < 15; i++) begin
			tick(1);
			check(m_ocmd, 1'b0, "motion after override");
		end
	endtask : t_override
	// mains without feedback counts open as soon as the open coil fires
	task automatic t_no_feedback();
		fb_cfg = 2'h2;
		m_os = 1;
		for (int i = 0; i < 10 && m_led !== 1'b0; i++) tick(1);
		check(m_led, 1'b0, "not open on command");
		check(m_fo, 1'b0, "failed open without feedback");
		m_os = 0;
	endtask : t_no_feedback
	task automatic t_sync();
		ext_sync = 2'h2;
		g_cs = 1;
		for (int i = 0; i < 20 && g_se !== 1'b1; i++) tick(1);
		check(g_se, 1'b1, "no sync enable");
		check(sip, 1'b1, "no sync in progress");
		ext_man = 2'h1;
		m_sr = 1;
		sync_reached = 1;
		for (int i = 0; i < 20 && synced !== 1'b1; i++) tick(1);
		check(synced, 1'b1, "no synchronized");
	endtask : t_sync
	// gen breaker drops with its own source gone: no close failure may follow
	task automatic t_src_drop();
		for (int i = 0; i < 20 && g_led !== 1'b1; i++) tick(1);
		check(g_led, 1'b1, "gen not closed");
		g_cs = 0;
		src_pw = 2'h2;
		g_live = 0;
		ext_state = 2'h0;
		ext_en = 2'h2;
		for (int i = 0; i < 20 && g_led !== 1'b0; i++) tick(1);
		tick(3);
		check(g_led, 1'b0, "drop not shown");
		check(g_fc, 1'b0, "close failure with source off");
		ext_en = 2'h0;
	endtask : t_src_drop
	////////////////////////////////////////////////////////////////
	initial begin
		tick(6);
		resetn = 1;
		tick(4);
		t_close_consent();
		t_open_consent();
		t_fail();
		t_manual();
		t_inhibit();
		t_override();
		t_no_feedback();
		t_sync();
		t_src_drop();
		test_done();
	end
endmodule : tb_top

// *** src/breaker_handshake_io_logic.sv ***
`timescale 1ns/1ns
module breaker_handshake_io_logic
	import brk_pkg::*;
(
	input wire logic ref_clk,
	input wire logic resetn,
	input wire op_mode_t mode,
	input wire logic mains_brk_close_consent_in,
	input wire logic mains_brk_open_consent_in,
	input wire logic gen_brk_close_consent_in,
	input wire logic gen_brk_open_consent_in,
	input wire logic mains_brk_feedback_in,
	input wire logic gen_brk_feedback_in,
	input wire logic mains_brk_override_in,
	input wire logic gen_brk_override_in,
	input wire logic mains_brk_close_request_in,
	input wire logic mains_brk_open_request_in,
	input wire logic gen_brk_close_request_in,
	input wire logic gen_brk_open_request_in,
	input wire logic mains_brk_sync_request_in,
	input wire logic gen_brk_sync_request_in,
	input wire logic mains_brk_inhibit_in,
	input wire logic mains_close_seq,
	input wire logic mains_open_seq,
	input wire logic gen_close_seq,
	input wire logic gen_open_seq,
	input wire logic mains_open_blackout,
	input wire logic gen_open_blackout,
	input wire logic [1:0] fb_cfg,
	input wire logic [1:0] close_consent_cfg,
	input wire logic [1:0] open_consent_cfg,
	input wire logic [DLY_W-1:0] consent_dly,
	input wire logic [DLY_W-1:0] fb_dly,
	input wire logic [1:0] src_powered,
	input wire logic mains_live,
	input wire logic gen_bus_live,
	input wire logic [1:0] ext_sync_used,
	input wire logic [1:0] ext_managed,
	input wire logic sync_reached,
	output logic mains_brk_ready_close_out,
	output logic mains_brk_ready_open_out,
	output logic gen_brk_ready_close_out,
	output logic gen_brk_ready_open_out,
	output logic mains_brk_close_cmd,
	output logic mains_brk_open_cmd,
	output logic gen_brk_close_cmd,
	output logic gen_brk_open_cmd,
	output logic mains_brk_closed_led,
	output logic gen_brk_closed_led,
	output logic mains_brk_fail_close,
	output logic mains_brk_fail_open,
	output logic gen_brk_fail_close,
	output logic gen_brk_fail_open,
	output logic gen_brk_sync_enable_out,
	output logic mains_brk_sync_enable_out,
	output logic sync_in_progress_out,
	output logic synchronized_out
);
	localparam int NIN = 13;
	logic [1:0] rst_sync;
	logic rst_n;
	logic [NIN-1:0] raw;
	logic [NIN-1:0] meta;
	logic [NIN-1:0] s;
	logic manual;
	logic inhibit_act;
	logic [1:0] sync_en;
	logic [1:0] sreq_meta;
	logic [1:0] sreq;
	logic internal_sync_hit;
	brk_if mb();
	brk_if gb();

	// reset falls at once but rises in step with the clock
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) rst_sync <= 2'h0;
		else rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_n = rst_sync[1];

	assign raw = {mains_brk_close_consent_in, mains_brk_open_consent_in, gen_brk_close_consent_in,
		gen_brk_open_consent_in, mains_brk_feedback_in, gen_brk_feedback_in, mains_brk_override_in,
		gen_brk_override_in, mains_brk_close_request_in, mains_brk_open_request_in,
		gen_brk_close_request_in, gen_brk_open_request_in, mains_brk_inhibit_in};
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			s <= '0;
		end else begin
			meta <= raw; // [R17]
			s <= meta;
		end
	end

	// sync requests are pins as well and get the same two flops
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sreq_meta <= 2'h0;
			sreq <= 2'h0;
		end else begin
			sreq_meta <= {gen_brk_sync_request_in, mains_brk_sync_request_in}; // [R17]
			sreq <= sreq_meta;
		end
	end

	assign manual = mode == MODE_MAN; // [R10]
	assign inhibit_act = s[0] && (mode == MODE_AUTO || mode == MODE_TEST_REMOTE); // [R12]

	////////////////////////////////////////////////////////////////////////////////
	assign mb.close_req = !inhibit_act && (mains_close_seq || (manual && s[4])); // [R10] [R12]
	assign mb.open_req = inhibit_act || mains_open_seq || (manual && s[3]); // [R12]
	assign mb.blackout = mains_open_blackout;
	assign mb.override = s[6];
	assign mb.feedback = s[8];
	assign mb.fb_cfg = fb_cfg[0];
	assign mb.close_consent = s[12];
	assign mb.close_consent_cfg = close_consent_cfg[0];
	assign mb.open_consent = s[11];
	assign mb.open_consent_cfg = open_consent_cfg[0];
	assign mb.consent_dly = consent_dly;
	assign mb.fb_dly = fb_dly;
	assign mb.src_powered = src_powered[0];
	assign mb.src_live = mains_live; // [R7]
	assign gb.close_req = gen_close_seq || (manual && s[2]); // [R10]
	assign gb.open_req = gen_open_seq || (manual && s[1]);
	assign gb.blackout = gen_open_blackout;
	assign gb.override = s[5];
	assign gb.feedback = s[7];
	assign gb.fb_cfg = fb_cfg[1];
	assign gb.close_consent = s[10];
	assign gb.close_consent_cfg = close_consent_cfg[1];
	assign gb.open_consent = s[9];
	assign gb.open_consent_cfg = open_consent_cfg[1];
	assign gb.consent_dly = consent_dly;
	assign gb.fb_dly = fb_dly;
	assign gb.src_powered = src_powered[1];
	assign gb.src_live = gen_bus_live; // [R7]

	brk_channel u_mains (.ref_clk(ref_clk), .rst_n(rst_n), .b(mb));
	brk_channel u_gen (.ref_clk(ref_clk), .rst_n(rst_n), .b(gb));

	////////////////////////////////////////////////////////////////////////////////
	// sync enable only while a breaker not externally managed waits to close on an external synchronizer
	assign sync_en[0] = ext_sync_used[0] && !ext_managed[0] && mb.close_req && !mb.state_closed; // [R13]
	assign sync_en[1] = ext_sync_used[1] && !ext_managed[1] && gb.close_req && !gb.state_closed; // [R13]
	// internal synchronizer serving an externally managed breaker on request
	assign internal_sync_hit = sync_reached
		&& ((ext_managed[0] && sreq[0]) || (ext_managed[1] && sreq[1])); // [R11] [R14]

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			mains_brk_ready_close_out <= 1'b0;
			mains_brk_ready_open_out <= 1'b0;
			gen_brk_ready_close_out <= 1'b0;
			gen_brk_ready_open_out <= 1'b0;
			mains_brk_close_cmd <= 1'b0;
			mains_brk_open_cmd <= 1'b0;
			gen_brk_close_cmd <= 1'b0;
			gen_brk_open_cmd <= 1'b0;
			mains_brk_closed_led <= 1'b0;
			gen_brk_closed_led <= 1'b0;
			mains_brk_fail_close <= 1'b0;
			mains_brk_fail_open <= 1'b0;
			gen_brk_fail_close <= 1'b0;
			gen_brk_fail_open <= 1'b0;
			gen_brk_sync_enable_out <= 1'b0;
			mains_brk_sync_enable_out <= 1'b0;
			sync_in_progress_out <= 1'b0;
			synchronized_out <= 1'b0;
		end else begin
			mains_brk_ready_close_out <= mb.ready_close; // [R1]
			mains_brk_ready_open_out <= mb.ready_open; // [R2]
			gen_brk_ready_close_out <= gb.ready_close; // [R1]
			gen_brk_ready_open_out <= gb.ready_open; // [R2]
			mains_brk_close_cmd <= mb.close_cmd;
			mains_brk_open_cmd <= mb.open_cmd;
			gen_brk_close_cmd <= gb.close_cmd;
			gen_brk_open_cmd <= gb.open_cmd;
			mains_brk_closed_led <= mb.state_closed; // [R15]
			gen_brk_closed_led <= gb.state_closed; // [R15]
			mains_brk_fail_close <= mb.fail_close;
			mains_brk_fail_open <= mb.fail_open;
			gen_brk_fail_close <= gb.fail_close;
			gen_brk_fail_open <= gb.fail_open;
			mains_brk_sync_enable_out <= sync_en[0]; // [R13]
			gen_brk_sync_enable_out <= sync_en[1]; // [R13]
			sync_in_progress_out <= |sync_en; // [R13]
			synchronized_out <= internal_sync_hit; // [R14]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	a_inhibit_no_close: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R12]
		inhibit_act |-> ##3 !mains_brk_close_cmd) else $error("mains closes under inhibit");
	a_sync_progress: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R13]
		sync_in_progress_out == (gen_brk_sync_enable_out || mains_brk_sync_enable_out))
		else $error("progress mismatch");

	// a ready output and its own command never stand in the same cycle
	a_ready_close_mains: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R1]
		mains_brk_ready_close_out |-> !mains_brk_close_cmd) else $error("mains closes while waiting");
	a_ready_close_gen: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R1]
		gen_brk_ready_close_out |-> !gen_brk_close_cmd) else $error("gen closes while waiting");
	a_ready_open_mains: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R2]
		mains_brk_ready_open_out |-> !mains_brk_open_cmd) else $error("mains opens while waiting");
	a_ready_open_gen: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R2]
		gen_brk_ready_open_out |-> !gen_brk_open_cmd) else $error("gen opens while waiting");

	// a synced override pin reaches the command outputs two edges later
	a_override_mains_idle: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R8]
		s[6] |-> ##2 !mains_brk_close_cmd && !mains_brk_open_cmd)
		else $error("mains commanded under override");
	a_override_gen_idle: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R8]
		s[5] |-> ##2 !gen_brk_close_cmd && !gen_brk_open_cmd)
		else $error("gen commanded under override");

	// no request from the external logic, no synchronized status
	a_synced_idle: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R14]
		!(|sreq) |=> !synchronized_out) else $error("synchronized without request");
endmodule : breaker_handshake_io_logic

// *** src/brk_channel.sv ***
`timescale 1ns/1ns
module brk_channel
	import brk_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	brk_if.ctrl b
);
	brk_state_t state;
	brk_state_t next_state;
	logic [CNT_W-1:0] timer;
	logic [CNT_W-1:0] consent_lim;
	logic [CNT_W-1:0] fb_lim;
	logic consent_done_c;
	logic consent_done_o;
	logic fb_closed;
	logic close_timeout;
	logic open_timeout;
	logic fail_close;
	logic fail_open;

	assign consent_lim = CNT_W'(b.consent_dly) * CNT_W'(CYC_PER_UNIT);
	assign fb_lim = CNT_W'(b.fb_dly) * CNT_W'(CYC_PER_UNIT);
	assign consent_done_c = !b.close_consent_cfg || b.close_consent || timer >= consent_lim; // [R1]
	assign consent_done_o = !b.open_consent_cfg || b.open_consent || timer >= consent_lim; // [R2]
	// without feedback the commanded state is taken as reached
	assign fb_closed = b.fb_cfg ? b.feedback : (state == ST_CLOSED || state == ST_CLOSING); // [R6] [R15]
	assign close_timeout = timer >= fb_lim; // [R5]
	assign open_timeout = timer >= fb_lim; // [R5]

	always_comb begin
		next_state = state;
		if (b.override) begin
			next_state = fb_closed ? ST_CLOSED : ST_OPEN; // [R8] [R9]
		end else begin
			unique case (state)
				ST_OPEN: if (b.close_req) next_state = ST_WAIT_CLOSE_OK;
					else if (b.fb_cfg && b.feedback) next_state = ST_CLOSED; // [R9]
				ST_WAIT_CLOSE_OK: if (b.open_req) next_state = ST_OPEN;
					else if (consent_done_c) next_state = ST_CLOSING;
				// an open request, inhibit included, aborts a closing in progress
				ST_CLOSING: if (b.open_req) next_state = ST_OPENING; // [R12]
					else if (fb_closed || close_timeout) next_state = fb_closed ? ST_CLOSED : ST_OPEN;
				ST_CLOSED: if (b.open_req) next_state = b.blackout ? ST_WAIT_OPEN_OK : ST_OPENING; // [R2]
					else if (!fb_closed) next_state = ST_OPEN;
				ST_WAIT_OPEN_OK: if (consent_done_o) next_state = ST_OPENING;
				ST_OPENING: if (!fb_closed || open_timeout) next_state = fb_closed ? ST_CLOSED : ST_OPEN;
			endcase
		end
	end

	assign fail_close = !b.override && b.fb_cfg && ((state == ST_CLOSING && close_timeout && !b.feedback)
		|| (state == ST_CLOSED && !b.feedback && !(b.src_powered && !b.src_live))); // [R4] [R7]
	assign fail_open = !b.override && b.fb_cfg && state == ST_OPENING && open_timeout && b.feedback; // [R4]

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_OPEN;
			timer <= '0;
		end else begin
			state <= next_state;
			timer <= (next_state != state) ? '0 : timer + CNT_W'(1); // [R17]
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			b.ready_close <= 1'b0;
			b.ready_open <= 1'b0;
			b.close_cmd <= 1'b0;
			b.open_cmd <= 1'b0;
			b.state_closed <= 1'b0;
			b.fail_close <= 1'b0;
			b.fail_open <= 1'b0;
		end else begin
			b.ready_close <= next_state == ST_WAIT_CLOSE_OK && b.close_consent_cfg; // [R1]
			b.ready_open <= next_state == ST_WAIT_OPEN_OK && b.open_consent_cfg; // [R2]
			// commands are exclusive by state encoding
			b.close_cmd <= !b.override && next_state == ST_CLOSING; // [R8] [R16]
			b.open_cmd <= !b.override && next_state == ST_OPENING; // [R8] [R16]
			b.state_closed <= fb_closed; // [R15]
			b.fail_close <= (b.fail_close && !b.close_req) || fail_close; // [R4]
			b.fail_open <= (b.fail_open && !b.open_req) || fail_open; // [R4]
		end
	end

	a_cmd_exclusive: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R16]
		!(b.close_cmd && b.open_cmd)) else $error("open and close together");
	a_override_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n) // [R8]
		b.override |=> !b.close_cmd && !b.open_cmd) else $error("command under override");
endmodule : brk_channel

// *** src/brk_if.sv ***
`timescale 1ns/1ns
interface brk_if;
	logic close_req;
	logic open_req;
	logic blackout;
	logic override;
	logic feedback;
	logic fb_cfg;
	logic close_consent;
	logic close_consent_cfg;
	logic open_consent;
	logic open_consent_cfg;
	logic [15:0] consent_dly;
	logic [15:0] fb_dly;
	logic src_powered;
	logic src_live;
	logic ready_close;
	logic ready_open;
	logic close_cmd;
	logic open_cmd;
	logic state_closed;
	logic fail_close;
	logic fail_open;
	modport ctrl (input close_req, open_req, blackout, override, feedback, fb_cfg, close_consent,
		close_consent_cfg, open_consent, open_consent_cfg, consent_dly, fb_dly, src_powered, src_live,
		output ready_close, ready_open, close_cmd, open_cmd, state_closed, fail_close, fail_open);
	modport top (output close_req, open_req, blackout, override, feedback, fb_cfg, close_consent,
		close_consent_cfg, open_consent, open_consent_cfg, consent_dly, fb_dly, src_powered, src_live,
		input ready_close, ready_open, close_cmd, open_cmd, state_closed, fail_close, fail_open);
endinterface : brk_if

// *** src/brk_pkg.sv ***
// Operation
// [R1] ready-to-close asserted before closing; released on consent or delay expiry, then close
// [R2] ready-to-open only for blackout openings; released on consent or delay, then open
// [R3] feedback input is active while breaker closed, inactive while open
// [R4] feedback not following command raises failed-open or failed-close warning
// [R5] feedback delay is the maximum time to reach commanded state
// [R6] without feedback, breaker state follows the command immediately
// [R7] source-powered breaker dropping open with source absent raises no close-failed warning
// [R8] override active: no open or close commands issued to that breaker
// [R9] during override, commands track reported state so release causes no motion
// [R10] request inputs honoured only in manual mode, like panel buttons
// [R11] external logic raises sync-request to use the internal synchronizer
// [R12] closure inhibit in auto, test or remote start opens mains breaker and holds it
// [R13] external synchronizer enabled by per-breaker enable and in-progress outputs
// [R14] externally managed breaker with internal synchronizer: synchronized output on sync
// [R15] feedback gives breaker state even under external command; shown on indicators
// [R16] open and close commands never asserted together
// [R17] inputs synchronized to the clock; delays timed by clock counters
package brk_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int DELAY_UNIT_US = 1000;
	localparam int CYC_PER_UNIT = CLK_HZ / 1_000_000 * DELAY_UNIT_US;
	localparam int DLY_W = 16;
	// wide enough for the longest delay counted in clock cycles
	localparam int CNT_W = 33;
	typedef enum logic [1:0] {MODE_OFF, MODE_MAN, MODE_AUTO, MODE_TEST_REMOTE} op_mode_t;
	typedef enum {ST_OPEN, ST_WAIT_CLOSE_OK, ST_CLOSING, ST_CLOSED, ST_WAIT_OPEN_OK, ST_OPENING} brk_state_t;
endpackage : brk_pkg
